// >>> rtl/adcsq_pkg.sv
// Package: register map, field positions, reset values and timing for the ADC sequencer
package adcsq_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_CLKPWR     = 8'h04;
  localparam logic [7:0] OFS_RESULT_LO  = 8'h08;
  localparam logic [7:0] OFS_RESULT_HI  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h18;
  // Control register fields
  localparam int CH_LSB    = 0;
  localparam int DONE_BIT  = 6;
  localparam int START_BIT = 7;
  localparam int PCR_LSB   = 3;
  // Clock/power register fields
  localparam int DIV_LSB   = 0;
  localparam int PWROFF_BIT = 7;
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h40;
  localparam logic [7:0] CLKPWR_RST  = 8'h80;
  // Divider codes and terminal counts (period minus one) in system clocks
  localparam logic [2:0] DIV_CODE_2  = 3'h0;
  localparam logic [2:0] DIV_CODE_8  = 3'h1;
  localparam logic [2:0] DIV_CODE_32 = 3'h2;
  localparam logic [4:0] DIV_CNT_2   = 5'h01;
  localparam logic [4:0] DIV_CNT_8   = 5'h07;
  localparam logic [4:0] DIV_CNT_32  = 5'h1F;
  // Conversion length in converter clock periods
  localparam logic [4:0] CONV_PERIODS = 5'h10;
  // Sequencer states
  typedef enum logic [1:0]
  {
    ADCSQ_IDLE  = 2'b00,
    ADCSQ_RESET = 2'b01,
    ADCSQ_CONV  = 2'b10
  } adcsq_state_t;
endpackage

// >>> rtl/adcsq_top.sv
// ADC control sequencer: APB registers, channel/pin control, divider, conversion timing
// Summary of operation
// - Route exactly one of eight analog inputs to the converter by channel select.
// - Pin config 111 makes all eight shared pins analog inputs.
// - Pin config zero leaves all pins digital and powers converter down.
// - A start bit pulse 0 to 1 to 0 begins one conversion.
// - Rising start resets converter, forces done-low flag to 1, held while high.
// - Hardware clears done-low flag to 0 at end of conversion.
// - End of conversion sets interrupt flag; interrupt asserts only when enabled.
// - Divider field: 000 div 2, 001 div 8, 010 div 32, 011 undefined.
// - Converter on only when power-off bit is 0 and pin config non-zero.
// - Pull-ups disconnected on pins assigned as analog inputs.
// - Analog pins override the port direction register.
// - Conversion takes sixteen converter clock periods before clearing done-low.
// - Result bits 11..4 in high byte, bits 3..0 in low byte upper nibble.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module adcsq_top
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter analog core
  input  wire logic [11:0] conv_result,
  output logic      [2:0]  conv_channel,
  output logic             conv_power_on,
  output logic             conv_reset,
  output logic             conv_clk,
  // Port B pin control
  input  wire logic [7:0]  pin_pullup_req,
  input  wire logic [7:0]  port_direction_control,
  output logic      [7:0]  analog_input_pins,
  output logic      [7:0]  pin_pullup_en,
  output logic      [7:0]  pin_dir_input,
  // Interrupt
  output logic             irq
);

  // Register state
  logic [2:0]  analog_channel_select_q;
  logic [2:0]  pin_config_select_q;
  logic        start_q;
  logic        conversion_done_low_q;
  logic [2:0]  conv_clock_divider_select_q;
  logic        converter_power_off_q;
  logic [11:0] result_q;
  logic        irq_status_q;
  logic        irq_enable_q;
  adcsq_pkg::adcsq_state_t state_q;
  logic [4:0]  div_cnt_q;
  logic [4:0]  period_cnt_q;
  logic        start_prev_q;

  // Decoded strobes
  logic        apb_wr;
  logic        apb_rd;
  logic        conv_enable;
  logic        start_rise;
  logic        start_fall;
  logic        div_tick;
  logic        conv_end;
  logic [4:0]  div_top;
  logic [7:0]  analog_mask;

  assign apb_wr = psel && penable && pwrite && clk_en;
  assign apb_rd = psel && !penable && !pwrite;

  // Converter is live only with power bit clear and pins assigned
  assign conv_enable = !converter_power_off_q && (pin_config_select_q != 3'h0);

  assign start_rise = start_q && !start_prev_q;
  assign start_fall = !start_q && start_prev_q;

  // Divide ratio select; the undefined code falls back to the slowest safe ratio
  always_comb
  begin
    unique case (conv_clock_divider_select_q)
      adcsq_pkg::DIV_CODE_2:  div_top = adcsq_pkg::DIV_CNT_2;
      adcsq_pkg::DIV_CODE_8:  div_top = adcsq_pkg::DIV_CNT_8;
      adcsq_pkg::DIV_CODE_32: div_top = adcsq_pkg::DIV_CNT_32;
      default:                div_top = adcsq_pkg::DIV_CNT_32;
    endcase
  end

  assign div_tick = (div_cnt_q == div_top);
  assign conv_end = (state_q == adcsq_pkg::ADCSQ_CONV) && div_tick
                    && (period_cnt_q == adcsq_pkg::CONV_PERIODS - 5'h01);

  // Analog mask: contiguous from pin 0, count = 1 + config for non-zero config (000 gives none), 111 gives all eight
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_mask
      assign analog_mask[g] = (pin_config_select_q != 3'h0)
                              && (g <= 32'(pin_config_select_q));
    end
  endgenerate

  // APB answers in the access cycle with zero wait states
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > adcsq_pkg::OFS_IRQ_CLEAR);
    end
  end

  // Read data registered during setup; unmapped reads as zero
  always_ff @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (clk_en && apb_rd)
    begin
      unique case (paddr)
        adcsq_pkg::OFS_CONTROL:
          prdata <= {24'h000000, start_q, conversion_done_low_q,
                     pin_config_select_q, analog_channel_select_q};
        adcsq_pkg::OFS_CLKPWR:
          prdata <= {24'h000000, converter_power_off_q, 4'h0,
                     conv_clock_divider_select_q};
        adcsq_pkg::OFS_RESULT_LO:
          prdata <= {24'h000000, result_q[3:0], 4'h0};
        adcsq_pkg::OFS_RESULT_HI:
          prdata <= {24'h000000, result_q[11:4]};
        adcsq_pkg::OFS_IRQ_STATUS:
          prdata <= {31'h0000_0000, irq_status_q};
        adcsq_pkg::OFS_IRQ_ENABLE:
          prdata <= {31'h0000_0000, irq_enable_q};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      analog_channel_select_q <= adcsq_pkg::CONTROL_RST[2:0];
      pin_config_select_q     <= adcsq_pkg::CONTROL_RST[5:3];
      start_q                 <= adcsq_pkg::CONTROL_RST[7];
    end
    else if (apb_wr && paddr == adcsq_pkg::OFS_CONTROL)
    begin
      analog_channel_select_q <= pwdata[adcsq_pkg::CH_LSB +: 3];
      pin_config_select_q     <= pwdata[adcsq_pkg::PCR_LSB +: 3];
      start_q                 <= pwdata[adcsq_pkg::START_BIT];
    end
  end

  // Clock and power register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      conv_clock_divider_select_q <= adcsq_pkg::CLKPWR_RST[2:0];
      converter_power_off_q       <= adcsq_pkg::CLKPWR_RST[7];
    end
    else if (apb_wr && paddr == adcsq_pkg::OFS_CLKPWR)
    begin
      conv_clock_divider_select_q <= pwdata[adcsq_pkg::DIV_LSB +: 3];
      converter_power_off_q       <= pwdata[adcsq_pkg::PWROFF_BIT];
    end
  end

  // Start edge history
  always_ff @(posedge clk)
  begin
    if (rst)
      start_prev_q <= 1'b0;
    else if (clk_en)
      start_prev_q <= start_q;
  end

  // Divider free-runs only in conversion so periods align to the start
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_cnt_q <= 5'h00;
      conv_clk  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_q != adcsq_pkg::ADCSQ_CONV || div_tick)
        div_cnt_q <= 5'h00;
      else
        div_cnt_q <= div_cnt_q + 5'h01;
      conv_clk <= (state_q == adcsq_pkg::ADCSQ_CONV)
                  && (div_cnt_q <= (div_top >> 1)); // no carry out at /32
    end
  end

  // Sequencer: reset while start high, convert after falling edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q      <= adcsq_pkg::ADCSQ_IDLE;
      period_cnt_q <= 5'h00;
    end
    else if (clk_en)
    begin
      if (!conv_enable)
        state_q <= adcsq_pkg::ADCSQ_IDLE;
      else if (start_rise || start_q)
        state_q <= adcsq_pkg::ADCSQ_RESET;
      else
      begin
        unique case (state_q)
          adcsq_pkg::ADCSQ_IDLE:
            state_q <= adcsq_pkg::ADCSQ_IDLE;
          adcsq_pkg::ADCSQ_RESET:
            if (start_fall)
            begin
              state_q      <= adcsq_pkg::ADCSQ_CONV;
              period_cnt_q <= 5'h00;
            end
          adcsq_pkg::ADCSQ_CONV:
            if (div_tick)
            begin
              period_cnt_q <= period_cnt_q + 5'h01;
              if (conv_end)
                state_q <= adcsq_pkg::ADCSQ_IDLE;
            end
          default:
            state_q <= adcsq_pkg::ADCSQ_IDLE;
        endcase
      end
    end
  end

  // Done-low flag and result capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      conversion_done_low_q <= adcsq_pkg::CONTROL_RST[adcsq_pkg::DONE_BIT];
      result_q              <= 12'h000;
    end
    else if (clk_en)
    begin
      if (start_rise && conv_enable)
        conversion_done_low_q <= 1'b1;
      else if (conv_end)
      begin
        conversion_done_low_q <= 1'b0;
        result_q              <= conv_result;
      end
    end
  end

  // Sticky interrupt status: set wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_status_q <= 1'b0;
    else if (conv_end && clk_en)
      irq_status_q <= 1'b1;
    else if (apb_wr && paddr == adcsq_pkg::OFS_IRQ_CLEAR && pwdata[0])
      irq_status_q <= 1'b0;
  end

  // Interrupt enable register
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_enable_q <= 1'b0;
    else if (apb_wr && paddr == adcsq_pkg::OFS_IRQ_ENABLE)
      irq_enable_q <= pwdata[0];
  end

  // Registered outputs to converter, pins and interrupt
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      conv_channel      <= 3'h0;
      conv_power_on     <= 1'b0;
      conv_reset        <= 1'b1;
      analog_input_pins <= 8'h00;
      pin_pullup_en     <= 8'h00;
      pin_dir_input     <= 8'hFF;
      irq               <= 1'b0;
    end
    else if (clk_en)
    begin
      conv_channel      <= analog_channel_select_q;
      conv_power_on     <= conv_enable;
      conv_reset        <= (state_q != adcsq_pkg::ADCSQ_CONV) || start_q;
      analog_input_pins <= analog_mask;
      pin_pullup_en     <= pin_pullup_req & ~analog_mask;
      pin_dir_input     <= port_direction_control | analog_mask;
      irq               <= irq_status_q && irq_enable_q;
    end
  end

  // Assertions
  AST_DONE_SET: assert property (@(posedge clk) disable iff (rst)
    (clk_en && start_rise && conv_enable) |=> conversion_done_low_q)
    else $error("done-low flag not set on start rise");
  AST_DONE_CLR: assert property (@(posedge clk) disable iff (rst)
    (clk_en && conv_end && !start_rise) |=> !conversion_done_low_q)
    else $error("done-low flag not cleared at conversion end");
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (rst)
    (clk_en && conv_end) |=> irq_status_q)
    else $error("interrupt status not set at conversion end");
  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (rst)
    irq |-> $past(irq_enable_q))
    else $error("interrupt raised while disabled");
  AST_PWR: assert property (@(posedge clk) disable iff (rst)
    (clk_en && (converter_power_off_q || pin_config_select_q == 3'h0)) |=> !conv_power_on)
    else $error("converter powered while off");
  AST_ALL_ANALOG: assert property (@(posedge clk) disable iff (rst)
    (clk_en && pin_config_select_q == 3'h7) |=> analog_input_pins == 8'hFF)
    else $error("config 111 not all analog");
  AST_PULLUP: assert property (@(posedge clk) disable iff (rst)
    (pin_pullup_en & analog_input_pins) == 8'h00)
    else $error("pull-up left on analog pin");
  AST_DIR: assert property (@(posedge clk) disable iff (rst)
    (analog_input_pins & ~pin_dir_input) == 8'h00)
    else $error("analog pin not forced to input");
  AST_CHAN: assert property (@(posedge clk) disable iff (rst)
    clk_en |=> conv_channel == $past(analog_channel_select_q))
    else $error("channel not routed");
  AST_DIV2: assert property (@(posedge clk) disable iff (rst)
    (clk_en && state_q == adcsq_pkg::ADCSQ_CONV && div_cnt_q == 5'h00
     && conv_clock_divider_select_q == adcsq_pkg::DIV_CODE_2) |-> div_tick == 1'b0)
    else $error("divide by two period wrong");
  AST_START: assert property (@(posedge clk) disable iff (rst)
    (clk_en && state_q == adcsq_pkg::ADCSQ_RESET && start_fall && conv_enable)
    |=> state_q == adcsq_pkg::ADCSQ_CONV)
    else $error("conversion not begun on start fall");
  AST_LEN: assert property (@(posedge clk) disable iff (rst)
    conv_end |-> period_cnt_q == 5'h0F)
    else $error("conversion length not sixteen periods");
endmodule

// >>> verification/adc_control_sequencer_tb.sv
// Testbench for the ADC control sequencer: APB register, pin and conversion checks
`timescale 1ns/1ps
module adc_control_sequencer_tb;
  logic        clk;
  logic        rst;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] conv_result;
  logic [2:0]  conv_channel;
  logic        conv_power_on;
  logic        conv_reset;
  logic        conv_clk;
  logic [7:0]  pin_pullup_req;
  logic [7:0]  port_direction_control;
  logic [7:0]  analog_input_pins;
  logic [7:0]  pin_pullup_en;
  logic [7:0]  pin_dir_input;
  logic        irq;
  int          n_mismatch;
  int          n_tests;
  int          cyc;
  logic [31:0] rd;
  logic        er;
  int          t0;
  int          nb;
  int          n_rise;
  logic        cclk_prev;
  int          dv[3] = '{2, 8, 32};

  adcsq_top adcsq_top_inst
  (
    .clk                    (clk),
    .rst                    (rst),
    .clk_en                 (clk_en),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .conv_result            (conv_result),
    .conv_channel           (conv_channel),
    .conv_power_on          (conv_power_on),
    .conv_reset             (conv_reset),
    .conv_clk               (conv_clk),
    .pin_pullup_req         (pin_pullup_req),
    .port_direction_control (port_direction_control),
    .analog_input_pins      (analog_input_pins),
    .pin_pullup_en          (pin_pullup_en),
    .pin_dir_input          (pin_dir_input),
    .irq                    (irq)
  );

  // Clock and free cycle count used to time conversions
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Converter clock rising edges, counted per conversion
  always @(posedge clk)
  begin
    cclk_prev <= conv_clk;
    if (conv_clk === 1'b1 && cclk_prev === 1'b0)
      n_rise <= n_rise + 1;
  end

  // One APB transfer; waits on pready, no latency assumed
  // Starts one edge after the call so a release and a new setup never share a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Let a register write reach the registered outputs, then sample mid-cycle
  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog; a full run needs well under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    conv_result = 12'hA5C;
    pin_pullup_req = 8'hF0;
    port_direction_control = 8'h0C;
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    clk_en = 1'b1;
    n_rise = 0;
    cclk_prev = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and unmapped address
    apb(1'b0, adcsq_pkg::OFS_CONTROL, 32'h0);
    chk("control rst", 32'h40, rd);
    apb(1'b0, adcsq_pkg::OFS_CLKPWR, 32'h0);
    chk("clkpwr rst", 32'h80, rd);
    chk("power rst", 1'b0, conv_power_on);
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 1'b1, er);
    $display("test reset done");
    // Pin configuration: partial group, all, none, powered off
    apb(1'b1, adcsq_pkg::OFS_CLKPWR, 32'h00);
    apb(1'b1, adcsq_pkg::OFS_CONTROL, 32'h1D);
    settle();
    chk("channel", 3'h5, conv_channel);
    chk("analog pcr3", 8'h0F, analog_input_pins);
    chk("pullup", 8'hF0, pin_pullup_en);
    chk("dir", 8'h0F, pin_dir_input);
    chk("power on", 1'b1, conv_power_on);
    // Clock enable low: the direction output must ignore a changed input
    @(posedge clk);
    clk_en <= 1'b0;
    port_direction_control <= 8'h30;
    settle();
    chk("dir frozen", 8'h0F, pin_dir_input);
    @(posedge clk);
    clk_en <= 1'b1;
    settle();
    chk("dir thawed", 8'h3F, pin_dir_input);
    apb(1'b1, adcsq_pkg::OFS_CONTROL, 32'h3D);
    settle();
    chk("analog pcr7", 8'hFF, analog_input_pins);
    chk("pullup all", 8'h00, pin_pullup_en);
    apb(1'b1, adcsq_pkg::OFS_CONTROL, 32'h05);
    settle();
    chk("analog pcr0", 8'h00, analog_input_pins);
    chk("power pcr0", 1'b0, conv_power_on);
    apb(1'b1, adcsq_pkg::OFS_CONTROL, 32'h3D);
    apb(1'b1, adcsq_pkg::OFS_CLKPWR, 32'h80);
    settle();
    chk("power off", 1'b0, conv_power_on);
    $display("test pins done");
    // Conversions with every defined divider, interrupt on and off
    for (int i = 0; i < 3; i++)
    begin
      // Bench clock is far above the analog period limit; digital timing only
      apb(1'b1, adcsq_pkg::OFS_CLKPWR, 32'(i));
      apb(1'b1, adcsq_pkg::OFS_IRQ_ENABLE, 32'(i != 1));
      apb(1'b1, adcsq_pkg::OFS_CONTROL, 32'hBA);
      apb(1'b0, adcsq_pkg::OFS_CONTROL, 32'h0);
      chk("start held", 32'hFA, rd);
      chk("conv reset", 1'b1, conv_reset);
      nb = n_rise;
      apb(1'b1, adcsq_pkg::OFS_CONTROL, 32'h3A);
      t0 = cyc;
      rd = 32'h40;
      while (rd[6] !== 1'b0 && cyc - t0 < 2000)
        apb(1'b0, adcsq_pkg::OFS_CONTROL, 32'h0);
      chk("done low", 32'h3A, rd);
      chk("conv span", 1'b1, (cyc - t0 >= 16 * dv[i]) && (cyc - t0 <= 16 * dv[i] + 8));
      chk("conv clk rises", 32'h10, 32'(n_rise - nb));
      apb(1'b0, adcsq_pkg::OFS_IRQ_STATUS, 32'h0);
      chk("status", 32'h1, rd);
      chk("irq", 1'(i != 1), irq);
      apb(1'b0, adcsq_pkg::OFS_RESULT_HI, 32'h0);
      chk("result hi", 32'hA5, rd);
      apb(1'b0, adcsq_pkg::OFS_RESULT_LO, 32'h0);
      chk("result lo", 32'hC0, rd);
      apb(1'b1, adcsq_pkg::OFS_IRQ_CLEAR, 32'h1);
      settle();
      chk("irq clear", 1'b0, irq);
      apb(1'b0, adcsq_pkg::OFS_IRQ_STATUS, 32'h0);
      chk("status clear", 32'h0, rd);
      $display("test conversion %0d done", i);
    end
    complete_run();
  end
endmodule
